// ==== src/dpsr_pkg.sv ====
`default_nettype none
package dpsr_pkg;
  localparam int DPSR_DATA_W = 18;
  localparam int DPSR_ADDR_W = 20;
  localparam int DPSR_LANE_W = 9;
  localparam int DPSR_BURST = 2;
  localparam logic [2:0] DPSR_STRAP_WAIT = 3'h5;
  localparam logic [2:0] DPSR_RST_CNT = 3'h0;

  typedef struct packed {
    logic k;
    logic k_n;
    logic c;
    logic c_n;
  } dpsr_clk_s;

  typedef struct packed {
    logic rps_n;
    logic wps_n;
  } dpsr_sel_s;
endpackage
`default_nettype wire

// ==== src/dpsr_core.sv ====
`default_nettype none
// Overview of operation
// - every read or write starts only on a rising edge of the positive input clock.
// - synchronous inputs are captured on the positive and negative input clock rises.
// - the second half of a double-rate input is captured on the negative input clock rise.
// - in single-clock mode read data launches on the input clock pair.
// - free-running echo clocks follow the output clock pair.
// - in single-clock mode the echo clocks follow the input clock pair.
// - a low dll disable input turns the delay loop off and output timing changes.
// - each access moves two words of 18 or 36 bits within one cycle.
// - one address bus carries the read address and later the write address.
// - read and write data use separate ports that never turn around.
// - write data is registered on both input clock rises.
// - read data comes from registers clocked by the output clock pair rises.
// - port selects and lane selects are registered before they act.
// - a low read select at positive input rise starts a read, high leaves outputs off.
// - word one drives at negative output rise of t+1, word two at positive rise of t+2.
// - each low lane select writes its 9-bit lane and other lanes stay unchanged.
module dpsr_core
  import dpsr_pkg::*;
#(
  parameter int DATA_W = DPSR_DATA_W,
  parameter int ADDR_W = DPSR_ADDR_W
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic K,
  input wire logic K_N,
  input wire logic C,
  input wire logic C_N,
  input wire logic READ_PORT_SELECT_N,
  input wire logic WRITE_PORT_SELECT_N,
  input wire logic [DATA_W/DPSR_LANE_W-1:0] BYTE_LANE_WRITE_N,
  input wire logic [ADDR_W-1:0] A,
  input wire logic [DATA_W-1:0] D,
  input wire logic DLL_DISABLE_N,
  output logic [DATA_W-1:0] Q,
  output logic Q_OE_N,
  output logic ECHO_CLOCK_POS,
  output logic ECHO_CLOCK_NEG,
  output logic SINGLE_CLOCK_MODE
);
  localparam int LANES = DATA_W / DPSR_LANE_W;
  localparam int IN_W = 1 + 4 + 2 + LANES + ADDR_W + DATA_W;

  if (!(DATA_W == 18 || DATA_W == 36) || ADDR_W < 1 || ADDR_W > 24) begin : g_chk
    $error("dpsr_core: DATA_W must be 18 or 36, ADDR_W 1..24");
  end

  // three-stage pin sampler; a bit moves only once stages two and three agree
  logic [IN_W-1:0] s1, s2, s3, filt;
  wire [IN_W-1:0] raw = {DLL_DISABLE_N, K, K_N, C, C_N, READ_PORT_SELECT_N,
                         WRITE_PORT_SELECT_N, BYTE_LANE_WRITE_N, A, D};
  wire [IN_W-1:0] pin = (s2 & s3) | (filt & (s2 ^ s3));

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
    end else if (CE) begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      filt <= pin;
    end
  end

  wire [DATA_W-1:0] d_in = pin[DATA_W-1:0];
  wire [ADDR_W-1:0] a_in = pin[DATA_W +: ADDR_W];
  wire [LANES-1:0] bws_in = pin[DATA_W+ADDR_W +: LANES];
  dpsr_sel_s sel;
  dpsr_clk_s clk_now, clk_old;
  assign sel = pin[DATA_W+ADDR_W+LANES +: 2];
  assign clk_now = pin[DATA_W+ADDR_W+LANES+2 +: 4];
  assign clk_old = filt[DATA_W+ADDR_W+LANES+2 +: 4];
  wire dll_n = pin[IN_W-1];

  wire k_rise = clk_now.k & ~clk_old.k;
  wire kn_rise = clk_now.k_n & ~clk_old.k_n;
  wire c_rise = clk_now.c & ~clk_old.c;
  wire cn_rise = clk_now.c_n & ~clk_old.c_n;

  // strap: C and C_N high after reset select single-clock mode, fixed until next reset
  // sampler shows zeros for three edges, so the strap is read after it has filled
  logic [2:0] strap_cnt;
  logic single;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      strap_cnt <= DPSR_RST_CNT;
      single <= 1'b0;
    end else if (CE && strap_cnt != DPSR_STRAP_WAIT) begin
      strap_cnt <= strap_cnt + 3'h1;
      single <= clk_now.c & clk_now.c_n;
    end
  end
  assign SINGLE_CLOCK_MODE = single;

  wire op_rise = single ? k_rise : c_rise;
  wire on_rise = single ? kn_rise : cn_rise;

  // array of bursts, split per lane; word 0 and word 1 of a location
  logic [ADDR_W-1:0] ra1, ra2, ra_out;
  wire [DATA_W-1:0] rd0, rd1;

  // write side
  logic wr_pend;
  logic [DATA_W-1:0] wr_d0;
  logic [LANES-1:0] wr_b0;
  wire wr_start = CE & k_rise & ~sel.wps_n;
  // second word taken on following negative rise
  wire wr_commit = CE & kn_rise & wr_pend;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_pend <= 1'b0;
      wr_d0 <= '0;
      wr_b0 <= '1;
    end else if (CE) begin
      if (wr_start) begin
        wr_pend <= 1'b1;
        wr_d0 <= d_in;
        wr_b0 <= bws_in;
      end else if (wr_commit) begin
        wr_pend <= 1'b0;
      end
    end
  end

  // word two and write address on negative rise
  // address reused for the write half
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    // own arrays per lane, so each array has a single writer
    logic [DPSR_LANE_W-1:0] lane0 [2**ADDR_W];
    logic [DPSR_LANE_W-1:0] lane1 [2**ADDR_W];
    always_ff @(posedge CLK) begin
      if (wr_commit && !wr_b0[l]) begin
        lane0[a_in] <= wr_d0[l*DPSR_LANE_W +: DPSR_LANE_W];
      end
      if (wr_commit && !bws_in[l]) begin
        lane1[a_in] <= d_in[l*DPSR_LANE_W +: DPSR_LANE_W];
      end
    end
    assign rd0[l*DPSR_LANE_W +: DPSR_LANE_W] = lane0[ra2];
    assign rd1[l*DPSR_LANE_W +: DPSR_LANE_W] = lane1[ra_out];
  end

  // read side
  logic rd_s1, rd_s2, w1_pend;
  logic [DATA_W-1:0] q_core, q_late, q_pin;
  logic oe_n_core, oe_n_late, oe_n_pin;
  wire rd_start = k_rise & ~sel.rps_n;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_s1 <= 1'b0;
      rd_s2 <= 1'b0;
      ra1 <= '0;
      ra2 <= '0;
    end else if (CE && k_rise) begin
      rd_s1 <= rd_start;
      rd_s2 <= rd_s1;
      ra1 <= rd_start ? a_in : ra1;
      ra2 <= ra1;
    end
  end

  // array is read at launch, so a write just committed is forwarded for free
  // two words per access
  // output registers on output clock rises
  // word one on neg rise, word two on pos rise
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      w1_pend <= 1'b0;
      ra_out <= '0;
      q_core <= '0;
      oe_n_core <= 1'b1;
    end else if (CE) begin
      if (on_rise && rd_s2) begin
        w1_pend <= 1'b1;
        ra_out <= ra2;
        q_core <= rd0;
        oe_n_core <= 1'b0;
      end else if (op_rise) begin
        w1_pend <= 1'b0;
        q_core <= w1_pend ? rd1 : q_core;
        // deselected port floats after the next positive output rise
        oe_n_core <= ~w1_pend;
      end
    end
  end

  // loop off adds one sample of output delay
  // echo clocks track the output pair
  // single-clock echo from the input pair
  logic echo_p, echo_n;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      q_late <= '0;
      oe_n_late <= 1'b1;
      q_pin <= '0;
      oe_n_pin <= 1'b1;
      echo_p <= 1'b0;
      echo_n <= 1'b0;
    end else if (CE) begin
      q_late <= q_core;
      oe_n_late <= oe_n_core;
      q_pin <= dll_n ? q_core : q_late;
      oe_n_pin <= dll_n ? oe_n_core : oe_n_late;
      echo_p <= single ? clk_now.k : clk_now.c;
      echo_n <= single ? clk_now.k_n : clk_now.c_n;
    end
  end

  // output bus only ever driven, input bus only ever read
  assign Q = q_pin;
  assign Q_OE_N = oe_n_pin;
  assign ECHO_CLOCK_POS = echo_p;
  assign ECHO_CLOCK_NEG = echo_n;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_rd_start_kpos: assert property ($rose(rd_s1) |-> $past(k_rise))
    else $error("read began off a positive input rise");
  a_wr_cap_kpos: assert property (wr_start |=> wr_pend && wr_d0 == $past(d_in))
    else $error("write word one not captured");
  a_wr_cap_kneg: assert property (wr_commit && !wr_start |=> !wr_pend)
    else $error("write not committed on negative rise");
  a_sel_reg: assert property ($rose(wr_pend) |-> $past(k_rise && !sel.wps_n))
    else $error("write pending without registered select");
  a_single_launch: assert property (single |-> op_rise == k_rise && on_rise == kn_rise)
    else $error("single-clock mode launches on wrong clock");
  a_q_edge_only: assert property ($changed(q_core) |-> $past(CE && (op_rise || on_rise)))
    else $error("read data changed off an output edge");
  a_echo_follow: assert property (CE |=> echo_p == $past(single ? clk_now.k : clk_now.c))
    else $error("positive echo does not track its clock");
  a_echo_single: assert property (single && CE |=> echo_n == $past(clk_now.k_n))
    else $error("negative echo not from input pair in single mode");
  a_dll_delay: assert property ((CE && !dll_n) [*3] |-> q_pin == $past(q_core, 2))
    else $error("loop-off output not delayed by one sample");
  a_second_word: assert property (CE && op_rise && w1_pend && !(on_rise && rd_s2)
    |=> !w1_pend && !oe_n_core)
    else $error("second word not driven on positive output rise");
  a_rd_release: assert property (CE && op_rise && !w1_pend && !(on_rise && rd_s2)
    |=> oe_n_core)
    else $error("read port not released after deselect");

  c_read: cover property (CE && on_rise && rd_s2 ##[1:40] CE && op_rise && w1_pend);
  c_write: cover property (wr_start ##[1:40] wr_commit);
  c_back_reads: cover property (CE && rd_start ##[1:60] CE && rd_start && rd_s1);
endmodule // dpsr_core
`default_nettype wire

// ==== dv/dpsr_ctrl_model.sv ====
`default_nettype none
module dpsr_ctrl_model
  import dpsr_pkg::*;
(
  input wire logic strap,
  output wire dpsr_clk_s clk
);
  timeunit 1ns;
  timeprecision 100ps;
  logic k = 1'b0;
  logic k_d = 1'b0;
  // free running k, accesses only at its rise
  always #24 k = ~k;
  // output pair trails by board flight time
  always @(k) k_d <= #3 k;
  // one k period holds both halves of a burst
  assign clk = '{k: k, k_n: ~k, c: strap | k_d, c_n: strap | ~k_d};
endmodule // dpsr_ctrl_model
`default_nettype wire

// ==== dv/dpsr_tb_top.sv ====
`default_nettype none
module dpsr_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dpsr_pkg::*;
  localparam int AW = 6;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic strap = 1'b0;
  logic rps_n = 1'b1;
  logic wps_n = 1'b1;
  logic dll_n = 1'b1;
  logic [1:0] lane_n = 2'h3;
  logic [AW-1:0] a = '0;
  logic [17:0] d = '0;
  logic [17:0] w0 = 18'h3a5c1, w1 = 18'h1c3e7, n0 = 18'h0f0f0, n1 = 18'h2d2d2;
  logic [17:0] q;
  logic q_oe_n, echo_p, echo_n, single;
  dpsr_clk_s ck;
  int num_errors = 0;
  int samples_checked = 0;
  initial forever #2.5 clk = ~clk;
  dpsr_ctrl_model u_ctrl (.strap(strap), .clk(ck));
  dpsr_core #(.ADDR_W(AW)) u_dut (.CLK(clk), .RST_B(rst_b), .CE(1'b1), .K(ck.k), .K_N(ck.k_n),
    .C(ck.c), .C_N(ck.c_n), .READ_PORT_SELECT_N(rps_n), .WRITE_PORT_SELECT_N(wps_n),
    .BYTE_LANE_WRITE_N(lane_n), .A(a), .D(d), .DLL_DISABLE_N(dll_n), .Q(q), .Q_OE_N(q_oe_n),
    .ECHO_CLOCK_POS(echo_p), .ECHO_CLOCK_NEG(echo_n), .SINGLE_CLOCK_MODE(single));
  task automatic test_done();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmpb(input logic got, input logic exp);
    cmp({17'h0, got}, {17'h0, exp});
  endtask
  // bounded wait for a rise of clock field: 0 k, 1 k_n, 2 c, 3 c_n
  task automatic rise(input int sel);
    logic p;
    p = ck[3-sel];
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (!p && ck[3-sel]) return;
      p = ck[3-sel];
    end
    num_errors++;
    test_done();
  endtask
  // change pins well clear of the edge that takes them
  task automatic put(input int sel, input logic r, input logic w, input logic [AW-1:0] aa,
      input logic [17:0] dd, input logic [1:0] ll);
    rise(sel);
    @(negedge clk);
    rps_n = r;
    wps_n = w;
    a = aa;
    d = dd;
    lane_n = ll;
  endtask
  task automatic rw(input logic [AW-1:0] wa, input logic [17:0] d0, input logic [17:0] d1,
      input logic [1:0] l0, input logic [1:0] l1, input logic [17:0] e0, input logic [17:0] e1);
    int o;
    o = strap ? 0 : 2;
    put(1, 1, 0, wa, d0, l0);
    put(0, 1, 1, wa, d1, l1);
    put(1, 0, 1, wa, d1, 2'h3);
    put(0, 1, 1, wa, d1, 2'h3);
    rise(o + 1);
    rise(o + 1);
    cmpb(q_oe_n, 1'b1);
    repeat (7) @(negedge clk);
    cmpb(q_oe_n, 1'b0);
    cmp(q, e0);
    repeat (5) @(negedge clk);
    cmp(q, e1);
    repeat (16) @(negedge clk);
    cmpb(q_oe_n, 1'b1);
  endtask
  task automatic echo(input int o);
    for (int i = 0; i < 2; i++) begin
      rise(o + i);
      cmpb(i ? echo_n : echo_p, 1'b0);
      repeat (5) @(negedge clk);
      cmpb(i ? echo_n : echo_p, 1'b1);
    end
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (12) @(negedge clk);
    cmpb(single, 1'b0);
    rw(6'h05, w0, w1, 2'h0, 2'h0, w0, w1);
    rw(6'h3f, w1, w0, 2'h0, 2'h0, w1, w0);
    $display("test basic done");
    // word0 keeps its upper lane, word1 its lower lane
    rw(6'h05, n0, n1, 2'h2, 2'h1, {w0[17:9], n0[8:0]}, {n1[17:9], w1[8:0]});
    $display("test lanes done");
    echo(2);
    $display("test echo done");
    dll_n = 1'b0;
    rw(6'h11, n1, n0, 2'h0, 2'h0, n1, n0);
    dll_n = 1'b1;
    $display("test dll done");
    rst_b = 1'b0;
    strap = 1'b1;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (12) @(negedge clk);
    cmpb(single, 1'b1);
    echo(0);
    rw(6'h22, w1, n0, 2'h0, 2'h0, w1, n0);
    $display("test single done");
    test_done();
  end
endmodule // dpsr_tb_top
`default_nettype wire
